// *** verilog/sgrf_pkg.sv ***
package sgrf_pkg;
	// Option register (device config byte)
	localparam logic [7:0] OPT_OFFSET    = 8'h4d;
	localparam logic [7:0] OPT_RESET     = 8'h00;
	localparam int         OPT_ROM1M_BIT = 3;
	localparam int         OPT_IO32_BIT  = 4;
	localparam int         OPT_RTCEX_BIT = 5;
	localparam int         OPT_BYPASS_BIT = 6;
	// Controller (bridge end) Wishbone map
	localparam logic [3:0] CTL_OFFSET    = 4'h0;
	localparam logic [3:0] STAT_OFFSET   = 4'h4;
	localparam logic [3:0] OPTW_OFFSET   = 4'h8;
	localparam int         CTL_KEEP_BIT  = 0;
	localparam int         CTL_BUSY_BIT  = 1;
	localparam int         CTL_ACKF_BIT  = 2;
	localparam int         CTL_PWR_BIT   = 3;
	localparam int         CTL_XRST_BIT  = 4;
	// Timing
	localparam int         CLK_HZ        = 10000000;
	localparam int         RST_HOLD_US   = 1000;
	localparam int         RST_HOLD_CYC  = (RST_HOLD_US * (CLK_HZ / 1000000));
	localparam int         XRST_MIN_CYC  = 80;
	localparam int         MAX_SERVICE   = 3;
	// Round trip of the shared line through both synchronisers
	localparam int         ARB_SETTLE_CYC = 5;
	// Cycles in which the device's own flush pulse echoes back
	localparam int         FL_ECHO_CYC   = 2;
	// Window bases
	localparam logic [31:0] ROM512_BASE  = 32'hfff80000;
	localparam logic [31:0] ROM1M_BASE   = 32'hfff00000;
	localparam logic [15:0] BAR_HI_ZERO  = 16'h0000;
endpackage

// *** verilog/sgrf_if.sv ***
`timescale 1ns/1ns
interface sgrf_if;
	// Shared grant/busy line, open style two signals per party
	logic gbDevOut, gbDevOe, gbBrgOut, gbBrgOe;
	logic sharedGrantBusyLine;
	// Split-mode grant and busy (active low)
	logic splitGrantN, splitBusyN;
	// Power good, cpu reset, pci reset pin parts
	logic powerGoodIn, cpuResetOut;
	logic pciRstDevOut, pciRstDevOe, pciRstExtOut, pciRstExtOe;
	logic pciBusResetN;
	// Flush request/ack line parts
	logic flDevOut, flDevOe, flSysOut, flSysOe;
	logic flushReqAckLineN;
	// Straps
	logic splitHandshakeStrapN, resetModeStrap;
	// Wired levels: pulled high when nobody drives (active low signals)
	assign sharedGrantBusyLine = gbDevOe ? gbDevOut : (gbBrgOe ? gbBrgOut : 1'b1);
	assign pciBusResetN = pciRstDevOe ? pciRstDevOut : (pciRstExtOe ? pciRstExtOut : 1'b1);
	assign flushReqAckLineN = flDevOe ? flDevOut : (flSysOe ? flSysOut : 1'b1);
	modport device (input sharedGrantBusyLine, splitBusyN, powerGoodIn, pciBusResetN,
		flushReqAckLineN, splitHandshakeStrapN, resetModeStrap,
		output gbDevOut, gbDevOe, splitGrantN, cpuResetOut, pciRstDevOut, pciRstDevOe,
		flDevOut, flDevOe);
	modport bridge (input sharedGrantBusyLine, splitGrantN, cpuResetOut, pciBusResetN,
		flushReqAckLineN,
		output gbBrgOut, gbBrgOe, splitBusyN, powerGoodIn, pciRstExtOut, pciRstExtOe,
		flSysOut, flSysOe, splitHandshakeStrapN, resetModeStrap);
endinterface

// *** verilog/sgrf_sync.sv ***
`timescale 1ns/1ns
// Two-flop synchroniser, vector wide
module sgrf_sync #(parameter int W = 1, parameter logic [W-1:0] INIT = '0) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         reset,
	// Data
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] meta_r;  // First stage, read only by second

	// Two stages
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			meta_r <= INIT;
			dout   <= INIT;
		end else begin
			meta_r <= din;
			dout   <= meta_r;
		end
	end
endmodule

// *** verilog/sgrf_device.sv ***
`timescale 1ns/1ns
// Summary of operation
// - Shared line held asserted granting bridge
// - Revoke: drive deasserted one clock, release
// - Bridge reasserts next cycle to keep
// - No reassert: grant highest-priority requester
// - Bridge busy blocks grants until released
// - Bridge holds busy until bus idle
// - At most three requests, then bridge regranted
// - Split strap low: driven separate grant
// - Split mode: bridge asserts busy input
// - Power-good low: reset, cpu reset, pci reset
// - Internal mode: both resets held 1 ms
// - Strap low: tri-state, latch, pci reset input
// - External mode: cpu reset held 1 ms
// - External pci reset resets, cpu reset mirrors
// - External pci reset lasts at least 80 clocks
// - Flush request one clock, then tri-state
// - System acknowledges with one clock pulse
// - Bypass bit: internal ack, pin tri-stated
// - Bypass plus bit 5: rtc irq on pin
// - No bypass, bit 5: irq only masked
// - Bit 4: io decode width, BAR upper half
// - Bit 3: rom window 512 KB or 1 MB
module sgrf_device
	import sgrf_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	// Link pins
	sgrf_if.device           link,
	// Other masters' requests and grants (bit 0 highest priority)
	input  wire logic [3:0]  masterReq,
	output logic      [3:0]  masterGnt,
	input  wire logic        arbEnable,
	// Option register port
	input  wire logic        optWrite,
	input  wire logic [7:0]  optWdata,
	output logic      [7:0]  optRdata,
	// DMA flush side
	input  wire logic        dmaStart,
	output logic             dmaProceed,
	// RTC interrupt
	input  wire logic        rtcInterruptLine,
	output logic             rtcIrqInternal,
	// Decode checks
	input  wire logic [31:0] ioAddr,
	input  wire logic [31:0] memAddr,
	input  wire logic [15:0] barHiWdata,
	input  wire logic        barHiWrite,
	output logic      [15:0] barHiRdata,
	output logic             ioHit32,
	output logic             romHit,
	input  wire logic [15:0] ioBase,
	// Internal reset out
	output logic             internalReset
);
	typedef enum logic [3:0] {
		A_BRG  = 4'b0001,  // Bridge owns bus
		A_REVK = 4'b0010,  // Driving deasserted one clock
		A_WAIT = 4'b0100,  // Released, checking reassert
		A_OTHR = 4'b1000   // Another master granted
	} sgrf_arb_e;
	typedef enum logic [2:0] {
		F_IDLE = 3'b001,  // Nothing pending
		F_REQ  = 3'b010,  // Request pulse driven
		F_MON  = 3'b100   // Monitoring for ack
	} sgrf_fl_e;

	logic [7:0]  opt_r;           // Option register
	logic [15:0] barHi_r;         // Upper BAR half
	sgrf_arb_e   arb_r;           // Arbiter state
	logic [1:0]  served_r;        // Requests served since regrant
	logic [2:0]  waitCnt_r;       // Settle cycles after release
	logic [1:0]  echoCnt_r;       // Own flush pulse echo cycles
	logic [3:0]  gnt_r;           // Granted master
	sgrf_fl_e    fl_r;            // Flush state
	logic        proceed_r;       // DMA may go
	logic        extMode_r;       // Latched external reset mode
	logic [13:0] holdCnt_r;       // 1 ms reset hold counter
	logic        cpu_reset_out_r;        // Cpu reset level
	logic        pciRstDrv_r;     // Driving pci reset active
	logic        gbS, busyS, pgS, prstS, flS, strapS, modeS;  // Synchronised pins

	// Pins crossing from outside
	sgrf_sync #(.W(7), .INIT(7'h7f)) uSync (
		.clk   (clk),
		.reset (reset),
		.din   ({link.sharedGrantBusyLine, link.splitBusyN, link.powerGoodIn,
			link.pciBusResetN, link.flushReqAckLineN, link.splitHandshakeStrapN,
			link.resetModeStrap}),
		.dout  ({gbS, busyS, pgS, prstS, flS, strapS, modeS})
	);

	// Lowest set bit wins
	function automatic logic [3:0] pickFirst(input logic [3:0] r);
		return r & (~r + 4'h1);
	endfunction

	logic splitMode, bridgeBusy, inRst;
	assign splitMode  = ~strapS;
	assign bridgeBusy = splitMode ? ~busyS : ~gbS;
	// Internal reset from power-good or external pci reset
	assign inRst = ~pgS | (extMode_r & ~prstS);
	assign internalReset = inRst;

	// Option register; internal state reset too
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			opt_r <= OPT_RESET;
		end else if (inRst) begin
			opt_r <= OPT_RESET;
		end else if (optWrite) begin
			opt_r <= optWdata;
		end
	end
	assign optRdata = opt_r;

	// Upper BAR half, writable only in 32-bit mode
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			barHi_r <= BAR_HI_ZERO;
		end else if (inRst) begin
			barHi_r <= BAR_HI_ZERO;
		end else if (barHiWrite && opt_r[OPT_IO32_BIT]) begin
			barHi_r <= barHiWdata;
		end
	end
	assign barHiRdata = opt_r[OPT_IO32_BIT] ? barHi_r : BAR_HI_ZERO;
	// Decoders
	assign ioHit32 = opt_r[OPT_IO32_BIT] ? (ioAddr[31:16] == barHiRdata && ioAddr[15:0] == ioBase)
		: (ioAddr[15:0] == ioBase);
	assign romHit = opt_r[OPT_ROM1M_BIT] ? (memAddr >= ROM1M_BASE)
		: (memAddr >= ROM512_BASE);

	// Arbiter
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			waitCnt_r <= 3'h0;
			arb_r    <= A_BRG;
			served_r <= 2'h0;
			gnt_r    <= 4'h0;
		end else if (inRst || !arbEnable) begin
			waitCnt_r <= 3'h0;
			arb_r    <= A_BRG;
			served_r <= 2'h0;
			gnt_r    <= 4'h0;
		end else begin
			unique case (arb_r)
				A_BRG: begin
					served_r  <= 2'h0;
					waitCnt_r <= 3'h0;
					if (masterReq != 4'h0 && !(splitMode && bridgeBusy)) begin
						arb_r <= splitMode ? A_WAIT : A_REVK;
					end
				end
				A_REVK: arb_r <= A_WAIT;
				A_WAIT: begin
					// Stale line levels still in the pipe: wait for the reply
					if (waitCnt_r < 3'(ARB_SETTLE_CYC)) begin
						waitCnt_r <= waitCnt_r + 3'h1;
					// Bridge reasserted: hold until released
					end else if (bridgeBusy) begin
						arb_r <= A_WAIT;
					end else if (masterReq != 4'h0) begin
						gnt_r    <= pickFirst(masterReq);
						served_r <= served_r + 2'h1;
						arb_r    <= A_OTHR;
					end else begin
						arb_r <= A_BRG;
					end
				end
				A_OTHR: begin
					// No idle check here: busy release must mean idle
					if ((gnt_r & masterReq) == 4'h0) begin
						gnt_r <= 4'h0;
						if (masterReq != 4'h0 && served_r < 2'(MAX_SERVICE)) begin
							gnt_r    <= pickFirst(masterReq);
							served_r <= served_r + 2'h1;
						end else begin
							arb_r <= A_BRG;
						end
					end
				end
			endcase
		end
	end
	assign masterGnt = gnt_r;
	// Shared line: asserted (low) while bridge owns, high pulse, then released
	assign link.gbDevOe  = arbEnable && !splitMode && !inRst &&
		(arb_r == A_BRG || arb_r == A_REVK);
	// Asserted (low) while bridge owns, deasserted (high) for the revoke clock
	assign link.gbDevOut = (arb_r == A_REVK);
	// Split grant always driven
	assign link.splitGrantN = !(arb_r == A_BRG);

	// Reset sequencing: strap latched while power-good low
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			extMode_r <= 1'b0;
		end else if (!pgS) begin
			extMode_r <= ~modeS;
		end
	end
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			holdCnt_r <= 14'h0;
		end else if (!pgS) begin
			holdCnt_r <= 14'h0;
		end else if (holdCnt_r < 14'(RST_HOLD_CYC)) begin
			holdCnt_r <= holdCnt_r + 14'h1;
		end
	end
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cpu_reset_out_r    <= 1'b1;
			pciRstDrv_r <= 1'b0;
		end else begin
			cpu_reset_out_r    <= !pgS || holdCnt_r < 14'(RST_HOLD_CYC) ||
				(extMode_r && !prstS);
			pciRstDrv_r <= !extMode_r && modeS &&
				(!pgS || holdCnt_r < 14'(RST_HOLD_CYC));
		end
	end
	assign link.cpuResetOut  = cpu_reset_out_r;
	assign link.pciRstDevOe  = pciRstDrv_r;
	assign link.pciRstDevOut = 1'b0;

	// Flush handshake
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			echoCnt_r <= 2'h0;
			fl_r      <= F_IDLE;
			proceed_r <= 1'b0;
		end else if (inRst) begin
			echoCnt_r <= 2'h0;
			fl_r      <= F_IDLE;
			proceed_r <= 1'b0;
		end else begin
			proceed_r <= 1'b0;
			unique case (fl_r)
				F_IDLE: if (dmaStart) begin
					if (opt_r[OPT_BYPASS_BIT]) begin
						proceed_r <= 1'b1;
					end else begin
						fl_r <= F_REQ;
					end
				end
				F_REQ: begin
					fl_r      <= F_MON;
					echoCnt_r <= 2'h0;
				end
				// Own request returns through the synchroniser: not an ack
				F_MON: if (echoCnt_r < 2'(FL_ECHO_CYC)) begin
					echoCnt_r <= echoCnt_r + 2'h1;
				end else if (!flS) begin
					proceed_r <= 1'b1;
					fl_r      <= F_IDLE;
				end
			endcase
		end
	end
	assign dmaProceed = proceed_r;
	// Pin: request pulse, or rtc irq when bypassed and enabled
	assign link.flDevOe  = (fl_r == F_REQ) ||
		(opt_r[OPT_BYPASS_BIT] && opt_r[OPT_RTCEX_BIT]);
	assign link.flDevOut = (fl_r == F_REQ) ? 1'b0 : rtcInterruptLine;
	assign rtcIrqInternal = rtcInterruptLine & ~opt_r[OPT_RTCEX_BIT];
endmodule

// *** verilog/sgrf_bridge.sv ***
`timescale 1ns/1ns
// Bridge / system controller end, steered by Wishbone registers
module sgrf_bridge
	import sgrf_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Link pins
	sgrf_if.bridge           link
);
	logic [4:0]  ctl_r;          // Control bits
	logic        flSeen_r;       // Sticky: flush request seen
	logic [2:0]  ackSt_r;        // Ack pulse pipeline
	logic [7:0]  xCnt_r;         // External reset length
	logic        gbPrev_r;       // Previous shared level
	logic        keep_r;         // Driving busy on shared line
	logic        gbS, gntS, cpuS, flS;   // Synchronised
	logic        flPrev_r;

	sgrf_sync #(.W(4), .INIT(4'hf)) uSync (
		.clk   (clk),
		.reset (reset),
		.din   ({link.sharedGrantBusyLine, link.splitGrantN, link.cpuResetOut,
			link.flushReqAckLineN}),
		.dout  ({gbS, gntS, cpuS, flS})
	);

	// Bus slave, registered one-cycle ack the clock after strobe
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
			ctl_r    <= 5'h08;
		end else begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
			if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
				unique case (wb_adr_i)
					CTL_OFFSET: wb_dat_o <= {27'h0, ctl_r};
					STAT_OFFSET: wb_dat_o <= {27'h0, keep_r, flSeen_r, cpuS, gntS, gbS};
					default: wb_dat_o <= 32'h0;
				endcase
				if (wb_we_i && wb_sel_i[0] && wb_adr_i == CTL_OFFSET) begin
					ctl_r <= wb_dat_i[4:0];
				end
			end
		end
	end

	// Busy and keep on shared line (active low)
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			gbPrev_r <= 1'b1;
			keep_r   <= 1'b0;
		end else begin
			gbPrev_r <= gbS;
			if (!ctl_r[CTL_BUSY_BIT]) begin
				keep_r <= 1'b0;
			// Grant taken away (line went high): reassert to keep the bus
			end else if (!gbPrev_r && gbS) begin
				keep_r <= ctl_r[CTL_KEEP_BIT];
			end
		end
	end
	assign link.gbBrgOe  = keep_r;
	assign link.gbBrgOut = 1'b0;
	assign link.splitBusyN = !ctl_r[CTL_BUSY_BIT];
	assign link.powerGoodIn = ctl_r[CTL_PWR_BIT];
	assign link.splitHandshakeStrapN = 1'b1;
	assign link.resetModeStrap = 1'b1;

	// External reset pulse, at least 80 clocks
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			xCnt_r <= 8'h0;
		end else if (ctl_r[CTL_XRST_BIT]) begin
			xCnt_r <= 8'(XRST_MIN_CYC);
		end else if (xCnt_r != 8'h0) begin
			xCnt_r <= xCnt_r - 8'h1;
		end
	end
	assign link.pciRstExtOe  = xCnt_r != 8'h0;
	assign link.pciRstExtOut = 1'b0;

	// Flush ack: one-clock pulse after request seen (set wins over clear)
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			flPrev_r <= 1'b1;
			flSeen_r <= 1'b0;
			ackSt_r  <= 3'h0;
		end else begin
			flPrev_r <= flS;
			// Busy pipeline also hides the echo of our own ack pulse
			if (flPrev_r && !flS && ackSt_r == 3'h0) begin
				flSeen_r <= 1'b1;
			end else if (flSeen_r && ctl_r[CTL_ACKF_BIT]) begin
				flSeen_r <= 1'b0;
				ackSt_r  <= 3'h1;
			end else if (ackSt_r != 3'h0) begin
				ackSt_r <= (ackSt_r == 3'h5) ? 3'h0 : ackSt_r + 3'h1;
			end
		end
	end
	assign link.flSysOe  = ackSt_r == 3'h2;
	assign link.flSysOut = 1'b0;
endmodule

// *** tb/sgrf_assertions.sv ***
`timescale 1ns/1ns
// Watches the pins between the two ends
module sgrf_assertions
	import sgrf_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Pin parts of both parties
	input wire logic gbDevOut,
	input wire logic gbDevOe,
	input wire logic flDevOut,
	input wire logic flDevOe,
	input wire logic flSysOut,
	input wire logic flSysOe,
	input wire logic powerGoodIn,
	input wire logic cpuResetOut,
	input wire logic pciBusResetN,
	input wire logic pciRstExtOut,
	input wire logic pciRstExtOe,
	input wire logic resetModeStrap
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	// Cycles since power good came up, saturating so it never wraps
	logic [15:0] holdCnt_r;
	// Length of the running external reset pulse
	logic [7:0]  extCnt_r;
	// External agent pulls reset low
	logic        extAct;
	assign extAct = pciRstExtOe && !pciRstExtOut;
	// Power-good age counter
	always_ff @(posedge clk or posedge reset) begin
		if (reset || !powerGoodIn) begin
			holdCnt_r <= 16'h0;
		end else if (holdCnt_r != 16'hffff) begin
			holdCnt_r <= holdCnt_r + 16'h1;
		end
	end
	// External pulse length counter
	always_ff @(posedge clk or posedge reset) begin
		if (reset || !extAct) begin
			extCnt_r <= 8'h0;
		end else if (extCnt_r != 8'hff) begin
			extCnt_r <= extCnt_r + 8'h1;
		end
	end
	property p_revokeOne;
		(gbDevOe && gbDevOut) |=> !gbDevOe;
	endproperty
	property p_flReqOne;
		(flDevOe && !flDevOut) |=> !(flDevOe && !flDevOut);
	endproperty
	property p_flRelease;
		(flDevOe && !flDevOut) |-> ##[1:2] !flDevOe;
	endproperty
	property p_flAckOne;
		(flSysOe && !flSysOut) |=> !(flSysOe && !flSysOut);
	endproperty
	property p_pwrCpu;
		!powerGoodIn [*4] |-> cpuResetOut;
	endproperty
	property p_pwrPci;
		(!powerGoodIn && resetModeStrap) [*5] |-> !pciBusResetN;
	endproperty
	// Early cycles skipped: pins pass a two-flop synchroniser
	property p_hold;
		(powerGoodIn && holdCnt_r >= 16'd8 && holdCnt_r < RST_HOLD_CYC)
			|-> cpuResetOut && (!resetModeStrap || !pciBusResetN);
	endproperty
	property p_extHold;
		(extCnt_r != 8'h0 && !extAct) |-> extCnt_r >= 8'd80;
	endproperty
	a_revokeOne: assert property (p_revokeOne) else $error("revoke longer than one cycle");
	a_flReqOne: assert property (p_flReqOne) else $error("flush request too long");
	a_flRelease: assert property (p_flRelease) else $error("flush pin not released");
	a_flAckOne: assert property (p_flAckOne) else $error("flush ack too long");
	a_pwrCpu: assert property (p_pwrCpu) else $error("cpu reset missing");
	a_pwrPci: assert property (p_pwrPci) else $error("pci reset missing");
	a_hold: assert property (p_hold) else $error("reset released early");
	a_extHold: assert property (p_extHold) else $error("external reset too short");
	// Main scenarios reached
	c_revoke: cover property (gbDevOe && gbDevOut);
	c_flAck: cover property (flSysOe && !flSysOut);
	c_ext: cover property ($fell(extAct));
endmodule

// *** tb/standalone_grant_reset_flush_glue_tb.sv ***
`timescale 1ns/1ns
// Device and bridge joined; bench drives both user sides
module standalone_grant_reset_flush_glue_tb;
	import sgrf_pkg::*;
	// Option table row: opt and mem inputs, rom expected, bw input, br and irq expected
	typedef struct packed {
		logic [7:0]  opt;
		logic [31:0] mem;
		logic        rom;
		logic [15:0] bw;
		logic [15:0] br;
		logic        irq;
	} sgrf_row_s;
	logic        clk = 1'h0;
	logic        reset = 1'h1;
	logic [3:0]  masterReq = 4'h0;
	logic [3:0]  masterGnt;
	logic        arbEnable = 1'h1;
	logic        optWrite = 1'h0;
	logic [7:0]  optWdata = 8'h00;
	logic [7:0]  optRdata;
	logic        dmaStart = 1'h0;
	logic        dmaProceed;
	logic        rtcLine = 1'h1;
	logic        rtcIrq;
	logic [31:0] memAddr = 32'h0;
	logic [15:0] barW = 16'h0;
	logic        barWr = 1'h0;
	logic [15:0] barR;
	logic        romHit;
	logic        intRst;
	logic        cyc = 1'h0;
	logic        stb = 1'h0;
	logic        we = 1'h0;
	logic [3:0]  adr = 4'h0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic [31:0] q;
	logic        ack;
	logic [3:0]  prev;
	int          n;
	int          k;
	int          bad_count = 0;
	int          num_checks = 0;
	sgrf_row_s   rows[8] = '{
		'{8'h00, 32'hfff7ffff, 1'h0, 16'habcd, 16'h0000, 1'h1},
		'{8'h00, 32'hfff80000, 1'h1, 16'habcd, 16'h0000, 1'h1},
		'{8'h08, 32'hfff00000, 1'h1, 16'h1234, 16'h0000, 1'h1},
		'{8'h08, 32'hffefffff, 1'h0, 16'h1234, 16'h0000, 1'h1},
		'{8'h10, 32'hfff80000, 1'h1, 16'h1234, 16'h1234, 1'h1},
		'{8'h20, 32'h00000000, 1'h0, 16'h5a5a, 16'h0000, 1'h0},
		'{8'h60, 32'h00000000, 1'h0, 16'h5a5a, 16'h0000, 1'h0},
		'{8'h40, 32'hffffffff, 1'h1, 16'h5a5a, 16'h0000, 1'h1}};
	sgrf_if link();
	sgrf_device u_sgrf_device(.clk(clk), .reset(reset), .link(link), .masterReq(masterReq),
		.masterGnt(masterGnt), .arbEnable(arbEnable), .optWrite(optWrite),
		.optWdata(optWdata), .optRdata(optRdata), .dmaStart(dmaStart),
		.dmaProceed(dmaProceed), .rtcInterruptLine(rtcLine), .rtcIrqInternal(rtcIrq),
		.ioAddr(32'h0), .memAddr(memAddr), .barHiWdata(barW), .barHiWrite(barWr),
		.barHiRdata(barR), .ioHit32(), .romHit(romHit), .ioBase(16'h0),
		.internalReset(intRst));
	sgrf_bridge u_sgrf_bridge(.clk(clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .link(link));
	sgrf_assertions u_sgrf_assertions(.clk(clk), .reset(reset), .gbDevOut(link.gbDevOut),
		.gbDevOe(link.gbDevOe), .flDevOut(link.flDevOut), .flDevOe(link.flDevOe),
		.flSysOut(link.flSysOut), .flSysOe(link.flSysOe), .powerGoodIn(link.powerGoodIn),
		.cpuResetOut(link.cpuResetOut), .pciBusResetN(link.pciBusResetN),
		.pciRstExtOut(link.pciRstExtOut), .pciRstExtOe(link.pciRstExtOe),
		.resetModeStrap(link.resetModeStrap));
	// Free-running 10 MHz clock
	always #50 clk = ~clk;
	// Count and report one comparison
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// Single closing point of the run
	task automatic report_and_stop();
		if (bad_count == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic tick(input int c);
		repeat (c) @(posedge clk);
	endtask
	// Classic cycle; held until ack is sampled, bounded by a count
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		int t;
		t = 0;
		@(posedge clk);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		wdat <= d;
		@(posedge clk);
		while (ack !== 1'h1 && t < 50) begin
			@(posedge clk);
			t++;
		end
		q = rdat;
		if (t == 50) bad_count++;
		cyc <= 1'h0;
		stb <= 1'h0;
	endtask
	task automatic setOpt(input logic [7:0] v);
		@(posedge clk);
		optWrite <= 1'h1;
		optWdata <= v;
		@(posedge clk);
		optWrite <= 1'h0;
	endtask
	// One DMA start; counts proceed pulses and request drives
	task automatic flush(input int expGo, input int expDrv);
		int go;
		int drv;
		go = 0;
		drv = 0;
		@(posedge clk);
		dmaStart <= 1'h1;
		@(posedge clk);
		dmaStart <= 1'h0;
		repeat (60) begin
			@(posedge clk);
			if (dmaProceed === 1'h1) go++;
			if (link.flDevOe === 1'h1 && link.flDevOut === 1'h0) drv++;
		end
		chk("dmaProceed", go, expGo);
		chk("flushDrive", drv, expDrv);
	endtask
	// Cuts a hang short
	initial begin
		#3000000;
		bad_count++;
		report_and_stop();
	end
	initial begin
		tick(3);
		reset <= 1'h0;
		chk("optReset", optRdata, OPT_RESET);
		tick(RST_HOLD_CYC - 10);
		chk("cpuHold", link.cpuResetOut, 1'h1);
		chk("pciHold", link.pciBusResetN, 1'h0);
		for (n = 0; n < 100 && link.cpuResetOut !== 1'h0; n++) @(posedge clk);
		chk("cpuRun", link.cpuResetOut, 1'h0);
		chk("gbIdle", link.sharedGrantBusyLine, 1'h0);
		wb(1'h0, 4'hc, 32'h0);
		chk("unmapped", q, 32'h0);
		foreach (rows[i]) begin
			setOpt(rows[i].opt);
			memAddr <= rows[i].mem;
			barW <= rows[i].bw;
			barWr <= 1'h1;
			@(posedge clk);
			barWr <= 1'h0;
			tick(2);
			chk("optRdata", optRdata, rows[i].opt);
			chk("romHit", romHit, rows[i].rom);
			chk("barHi", barR, rows[i].br);
			chk("rtcIrq", rtcIrq, rows[i].irq);
		end
		setOpt(8'h00);
		masterReq <= 4'h6;
		for (n = 0; n < 100 && masterGnt === 4'h0; n++) @(posedge clk);
		chk("gntPrio", masterGnt, 4'h2);
		masterReq <= 4'h0;
		for (n = 0; n < 100 && link.gbDevOe !== 1'h1; n++) @(posedge clk);
		chk("gbBack", link.sharedGrantBusyLine, 1'h0);
		prev = 4'h0;
		k = 0;
		masterReq <= 4'hf;
		for (n = 0; n < 300; n++) begin
			@(posedge clk);
			if (masterGnt !== 4'h0 && masterGnt !== prev) k++;
			prev = masterGnt;
			masterReq <= masterReq & ~masterGnt;
			if (k > 0 && link.gbDevOe === 1'h1 && link.gbDevOut === 1'h0) break;
		end
		chk("grantsServed", k, 3);
		masterReq <= 4'h0;
		tick(30);
		wb(1'h1, CTL_OFFSET, 32'hb);
		masterReq <= 4'h1;
		k = 0;
		repeat (60) begin
			@(posedge clk);
			if (masterGnt !== 4'h0) k++;
		end
		chk("busyBlocks", k, 0);
		wb(1'h1, CTL_OFFSET, 32'h8);
		for (n = 0; n < 100 && masterGnt === 4'h0; n++) @(posedge clk);
		chk("gntAfterBusy", masterGnt, 4'h1);
		masterReq <= 4'h0;
		tick(30);
		wb(1'h1, CTL_OFFSET, 32'hc);
		flush(1, 1);
		setOpt(8'h40);
		flush(1, 0);
		setOpt(8'h00);
		wb(1'h1, CTL_OFFSET, 32'h8);
		flush(0, 1);
		setOpt(8'h08);
		wb(1'h1, CTL_OFFSET, 32'h0);
		tick(10);
		chk("pwrCpu", link.cpuResetOut, 1'h1);
		chk("pwrPci", link.pciBusResetN, 1'h0);
		chk("pwrInt", intRst, 1'h1);
		chk("pwrOpt", optRdata, 8'h00);
		wb(1'h1, CTL_OFFSET, 32'h8);
		tick(RST_HOLD_CYC - 10);
		chk("cpuHold2", link.cpuResetOut, 1'h1);
		for (n = 0; n < 100 && link.cpuResetOut !== 1'h0; n++) @(posedge clk);
		chk("cpuRun2", link.cpuResetOut, 1'h0);
		wb(1'h1, CTL_OFFSET, 32'h18);
		tick(100);
		wb(1'h1, CTL_OFFSET, 32'h8);
		tick(100);
		report_and_stop();
	end
endmodule
